// ### hw/phy_reset_map.vh
// Purpose: constants for the phy reset and strap sequencer
// Assumes: system clock of 100 MHz
// Notes:   times in their own unit, cycle counts derived from them
`ifndef PHY_RESET_MAP_VH
`define PHY_RESET_MAP_VH

`define CLK_PERIOD_PS        10000
// supply stable to reset release, ms
`define SUPPLY_SETTLE_MS     10
// warm reset low time, us
`define WARM_RESET_US        500
// management hold-off after release, us
`define MGMT_HOLDOFF_US      100
// release to strap pin drive, ns
`define STRAP_DRIVE_NS       6
`define STRAP_DRIVE_CYC      ((`STRAP_DRIVE_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define MGMT_HOLDOFF_CYC     ((`MGMT_HOLDOFF_US * 1000000) / `CLK_PERIOD_PS)
// hold-off counter reset value
`define HOLD_CNT_RESET       32'h00000000
// clock mode encodings
`define MODE_25MHZ           1'b0
`define MODE_50MHZ           1'b1
// strap reset value: floating decodes as one
`define STRAP_RESET_VAL      1'b1

`endif

// ### hw/phy_reset_strap_sequencer.v
// Purpose: reset, strap latch and clock mode logic inside the phy
// Assumes: reset_n_in is synchronous to clk_sys; 100 MHz clock
// Notes:   crystal_in sampled as a plain input
//
// What this block does
// - strap pins are latched at reset release on power-up and warm reset.
// - strap pins drive outputs only after release, at least 6 ns later.
// - strap pulled up or floating reads one, pulled down reads zero.
// - 25 MHz mode: crystal reference, RMII clock out toggles on each crystal change, so runs at the crystal rate.
// - 50 MHz mode: crystal input used directly as RMII reference.
`timescale 1ns/1ps
`default_nettype none
`include "phy_reset_map.vh"

module phy_reset_strap_sequencer #(
    parameter HOLDOFF_CYC = `MGMT_HOLDOFF_CYC
) (
    input  wire clk_sys,
    input  wire rst,
    input  wire reset_n_in,
    input  wire autoneg_speed_strap,
    input  wire clock_mode_strap,
    input  wire link_status,
    input  wire crystal_in,
    input  wire management_port_req,
    output reg  autoneg_speed_cfg_q,
    output reg  clock_mode_cfg_q,
    output reg  link_led_out,
    output reg  link_led_oe,
    output reg  crystal_out,
    output reg  rmii_ref_clk_q,
    output reg  phy_in_reset_q,
    output reg  management_ready_q,
    output reg  management_accept_q
);

// ----------------------------------------
// local sizes
// ----------------------------------------
// hold-off counter is wide enough for any sensible hold-off
localparam             CNT_W     = 32;
localparam [CNT_W-1:0] HOLD_LAST = HOLDOFF_CYC - 1;

reg             reset_n_q;
reg             drive_cnt_q;
reg [CNT_W-1:0] hold_cnt_q;
reg [CNT_W-1:0] hold_cnt_d;
reg             ready_d;
reg             accept_d;
reg             xtal_q;
reg             ref_clk_d;
reg             crystal_out_d;
wire            release_edge;
wire            pin_held;
wire            hold_done;

// ----------------------------------------
// pin state decodes
// ----------------------------------------
// release is the first cycle the pin reads high after reading low
assign release_edge = reset_n_in & ~reset_n_q;
assign pin_held     = ~reset_n_in;
assign hold_done    = (hold_cnt_q >= HOLD_LAST);

// ----------------------------------------
// reset pin sampling
// ----------------------------------------
always @(posedge clk_sys) begin
    if (rst) begin
        reset_n_q      <= 1'b0;
        phy_in_reset_q <= 1'b1;
    end else begin
        reset_n_q      <= reset_n_in;
        phy_in_reset_q <= pin_held;
    end
end

// ----------------------------------------
// strap latch
// ----------------------------------------
// straps are taken only on release, so later pin activity cannot
// disturb the configuration
always @(posedge clk_sys) begin
    if (rst) begin
        autoneg_speed_cfg_q <= `STRAP_RESET_VAL;
        clock_mode_cfg_q    <= `MODE_25MHZ;
    end else if (release_edge) begin
        // pad level: pull-up or float arrives high, pull-down low
        autoneg_speed_cfg_q <= autoneg_speed_strap;
        clock_mode_cfg_q    <= clock_mode_strap;
    end
end

// ----------------------------------------
// strap pin turn-around
// ----------------------------------------
// pin stays an input while held and two cycles past release
always @(posedge clk_sys) begin
    if (rst) begin
        drive_cnt_q  <= 1'b0;
        link_led_oe  <= 1'b0;
        link_led_out <= 1'b0;
    end else if (pin_held) begin
        drive_cnt_q <= 1'b0;
        link_led_oe <= 1'b0;
    end else begin
        if (reset_n_q) begin
            drive_cnt_q <= 1'b1;
        end
        link_led_oe  <= drive_cnt_q;
        link_led_out <= ~link_status;
    end
end

// ----------------------------------------
// management hold-off next value
// ----------------------------------------
always @* begin
    hold_cnt_d = hold_cnt_q;
    ready_d    = management_ready_q;
    if (pin_held) begin
        hold_cnt_d = `HOLD_CNT_RESET;
        ready_d    = 1'b0;
    end else if (reset_n_q && !management_ready_q) begin
        if (hold_done) begin
            ready_d = 1'b1;
        end else begin
            hold_cnt_d = hold_cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end
end

// ----------------------------------------
// management hold-off registers
// ----------------------------------------
always @(posedge clk_sys) begin
    if (rst) begin
        hold_cnt_q         <= `HOLD_CNT_RESET;
        management_ready_q <= 1'b0;
    end else begin
        hold_cnt_q         <= hold_cnt_d;
        management_ready_q <= ready_d;
    end
end

// ----------------------------------------
// management accept
// ----------------------------------------
// requests are dropped, not queued, while held or before hold-off ends
always @* begin
    accept_d = 1'b0;
    if (!pin_held) begin
        accept_d = management_port_req & management_ready_q;
    end
end

always @(posedge clk_sys) begin
    if (rst) begin
        management_accept_q <= 1'b0;
    end else begin
        management_accept_q <= accept_d;
    end
end

// ----------------------------------------
// reference clock next values
// ----------------------------------------
// the reference is sampled as data; the RMII clock toggles on each
// change of the sampled reference
always @* begin
    crystal_out_d = 1'b0;
    ref_clk_d     = crystal_in;
    case (clock_mode_cfg_q)
        `MODE_25MHZ: begin
            crystal_out_d = ~crystal_in;
            if (crystal_in ^ xtal_q) begin
                ref_clk_d = ~rmii_ref_clk_q;
            end else begin
                ref_clk_d = rmii_ref_clk_q;
            end
        end
        `MODE_50MHZ: begin
            crystal_out_d = 1'b0;
            ref_clk_d     = crystal_in;
        end
        default: begin
            crystal_out_d = 1'b0;
            ref_clk_d     = rmii_ref_clk_q;
        end
    endcase
end

// ----------------------------------------
// reference clock registers
// ----------------------------------------
always @(posedge clk_sys) begin
    if (rst) begin
        xtal_q         <= 1'b0;
        crystal_out    <= 1'b0;
        rmii_ref_clk_q <= 1'b0;
    end else begin
        xtal_q         <= crystal_in;
        crystal_out    <= crystal_out_d;
        rmii_ref_clk_q <= ref_clk_d;
    end
end

endmodule
`default_nettype wire

// ### test/phy_reset_checker_assertions.sv
// Purpose: port checks. Assumes: HOLDOFF_CYC is 8. Notes: bound from the bench
`timescale 1ns/1ps
`default_nettype none
module phy_reset_checker (input wire clk_sys, rst, reset_n_in, autoneg_speed_strap,
    clock_mode_strap, crystal_in, management_port_req, autoneg_speed_cfg_q, clock_mode_cfg_q,
    link_led_oe, rmii_ref_clk_q, crystal_out, management_ready_q, management_accept_q);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence released; $rose(reset_n_in); endsequence
    chk_strap_latch:
    assert property (released |=> autoneg_speed_cfg_q == $past(autoneg_speed_strap)
        && clock_mode_cfg_q == $past(clock_mode_strap)) else $error("strap not latched");
    chk_drive_gap:
    assert property (released |-> !link_led_oe ##1 !link_led_oe ##1 !link_led_oe
        ##1 (link_led_oe || !reset_n_in)) else $error("strap drive timing");
    chk_held_idle:
    assert property (!reset_n_in |=> !management_accept_q && !management_ready_q
        && !link_led_oe) else $error("activity in reset");
    chk_accept_ready:
    assert property (management_accept_q |-> $past(management_port_req)
        && $past(management_ready_q)) else $error("accept without ready");
    chk_mode_slow:
    assert property (!clock_mode_cfg_q ##1 !clock_mode_cfg_q |-> crystal_out == !$past(crystal_in))
        else $error("crystal out wrong");
    chk_mode_fast:
    assert property (clock_mode_cfg_q ##1 clock_mode_cfg_q |-> rmii_ref_clk_q == $past(crystal_in)
        && !crystal_out) else $error("ref clock not direct");
endmodule
`default_nettype wire

// ### test/phy_host_model.sv
// Purpose: reset and management controller. Assumes: scaled times. Notes: early requests during hold-off
`timescale 1ns/1ps
`default_nettype none
module phy_host_model (input wire logic clk_sys, go, early,
    output logic reset_n_in = 1'b0, output logic management_port_req = 1'b0);
    logic [7:0] n_q = 8'h00;
    always @(posedge clk_sys) begin
        n_q <= #1 go ? 8'h00 : n_q + {7'h00, n_q != 8'hFF};
        reset_n_in <= #1 !go && n_q >= 8'h14;
        management_port_req <= #1 early || n_q >= 8'h28;
    end
endmodule
`default_nettype wire

// ### test/phy_reset_strap_sequencer_test.sv
// Purpose: bench. Assumes: HOLDOFF_CYC 8. Notes: strap pin resolved from led enable
`timescale 1ns/1ps
`default_nettype none
module phy_reset_strap_sequencer_test;
    logic clk_sys = 1'b0, rst = 1'b1, go = 1'b0, early = 1'b0, pull = 1'b1, mode = 1'b0, xt = 1'b0;
    wire logic rn, req, c_a, c_m, led, oe, rdy, acc, pr, xo, rc;
    int n_fail = 0, n_compared = 0;
    wire logic strap = oe ? led : pull;
    phy_host_model phy_host_model_inst (.clk_sys(clk_sys), .go(go), .early(early),
        .reset_n_in(rn), .management_port_req(req));
    phy_reset_strap_sequencer #(.HOLDOFF_CYC(8)) phy_reset_strap_sequencer_inst (
        .clk_sys(clk_sys), .rst(rst), .reset_n_in(rn), .autoneg_speed_strap(strap),
        .clock_mode_strap(mode), .link_status(pull), .crystal_in(xt), .management_port_req(req),
        .autoneg_speed_cfg_q(c_a), .clock_mode_cfg_q(c_m), .link_led_out(led), .link_led_oe(oe),
        .crystal_out(xo), .rmii_ref_clk_q(rc), .phy_in_reset_q(pr), .management_ready_q(rdy),
        .management_accept_q(acc));
    initial forever #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) xt <= #1 ~xt;
    task chk(input string w, input logic s, input logic e);
        n_compared++;
        if (s !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %b seen %b", w, e, s);
        end
    endtask
    task boot(input logic p, input logic m);
        pull <= #1 p;
        mode <= #1 m;
        go <= #1 1'b1;
        @(posedge clk_sys);
        go <= #1 1'b0;
        repeat (5) @(posedge clk_sys);
        chk("accept in reset", acc, 1'b0);
        chk("in reset", pr, 1'b1);
        repeat (23) @(posedge clk_sys);
        chk("speed cfg", c_a, p);
        chk("mode cfg", c_m, m);
        chk("led drive", oe, 1'b1);
        chk("accept early", acc, 1'b0);
        chk("out of reset", pr, 1'b0);
        chk("crystal out", xo, m ? 1'b0 : xt);
        if (m) chk("ref clk", rc, ~xt);
        repeat (45) @(posedge clk_sys);
        chk("ready", rdy, 1'b1);
        chk("accept", acc, 1'b1);
    endtask
    task print_verdict;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk_sys);
        rst <= #1 1'b0;
        boot(1'b0, 1'b0);
        early <= #1 1'b1;
        boot(1'b1, 1'b1);
        print_verdict;
    end
    initial begin
        #20000;
        n_fail++;
        print_verdict;
    end
endmodule
bind phy_reset_strap_sequencer phy_reset_checker phy_reset_checker_inst (.*);
`default_nettype wire
